/* File: src/lbs_map.svh */
// register offsets, field positions, reset values and timing counts
`ifndef LBS_MAP_SVH
`define LBS_MAP_SVH

`define LBS_OFF_CTRL 8'h00
`define LBS_OFF_CMD 8'h04
`define LBS_OFF_LIM1 8'h08
`define LBS_OFF_LIM2 8'h0C
`define LBS_OFF_PAT 8'h10
`define LBS_OFF_STAT 8'h14

`define LBS_CTRL_STRB_BIT 0
`define LBS_CTRL_LIMEN_LSB 1
`define LBS_CTRL_POL_LSB 4
`define LBS_CMD_REPROC_BIT 0
`define LBS_CMD_PRESET_BIT 1
`define LBS_PAT_FAIL_LSB 4

`define LBS_POL_RESET 4'hF
`define LBS_LIMEN_RESET 2'h0

`define LBS_CLK_NS 8
`define LBS_STROBE_MIN_NS 10000
// strictly longer than the minimum, hence one extra cycle
`define LBS_STROBE_CYC ((`LBS_STROBE_MIN_NS / `LBS_CLK_NS) + 1)
`define LBS_CNT_W 12

`endif

/* File: src/lbs_pkg.sv */
// types shared by the binning strobe output block
package lbs_pkg;

    typedef struct packed {
        logic signed [15:0] hi;
        logic signed [15:0] lo;
    } lbs_lim_t;

    typedef struct packed {
        logic [3:0] pol;
        logic [1:0] lim_en;
        logic strobe_en;
    } lbs_ctrl_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SETTLE,
        ST_PULSE
    } lbs_fsm_t;

    typedef struct packed {
        logic done;
        logic [1:0] fail;
    } lbs_eval_t;

    typedef struct packed {
        lbs_ctrl_t ctrl;
        lbs_lim_t lim1;
        lbs_lim_t lim2;
        logic [3:0] pass_pat;
        logic [3:0] fail_pat;
        logic signed [15:0] reading;
        logic [1:0] fail;
        lbs_fsm_t fsm;
        logic [11:0] cnt;
        logic [3:0] pat;
        logic strb;
        logic pend;
        logic [3:0] pend_pat;
        logic [3:0] lines;
        logic wr;
        logic [7:0] waddr;
        logic [31:0] hrdata;
        logic rdy;
    } lbs_state_t;

endpackage

/* File: src/lbs_limit_eval.sv */
// registered two-window limit evaluator
`timescale 1ns/1ps
`default_nettype none

module lbs_limit_eval (
    // clock and reset
    input wire logic mclk_i,
    input wire logic nrst_i,
    // request
    input wire logic go_i,
    input wire logic signed [15:0] reading_i,
    input wire lbs_pkg::lbs_lim_t lim1_i,
    input wire lbs_pkg::lbs_lim_t lim2_i,
    input wire logic [1:0] lim_en_i,
    // result
    output logic done_o,
    output logic [1:0] fail_o
);

    lbs_pkg::lbs_eval_t st_q;
    lbs_pkg::lbs_eval_t st_d;

    function automatic logic out_of_win(input logic signed [15:0] rd, input lbs_pkg::lbs_lim_t lim);
        out_of_win = (rd < lim.lo) || (rd > lim.hi);
    endfunction

    always_comb begin
        st_d = st_q;
        st_d.done = go_i;
        if (go_i) begin
            st_d.fail[0] = lim_en_i[0] && out_of_win(reading_i, lim1_i);
            st_d.fail[1] = lim_en_i[1] && out_of_win(reading_i, lim2_i);
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign done_o = st_q.done;
    assign fail_o = st_q.fail;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);

    eval_timing_a: assert property (done_o == $past(go_i))
        else $error("evaluation result without a request");
    eval_hold_a: assert property (!go_i |=> $stable(fail_o))
        else $error("fail flags moved without an evaluation");

endmodule

`default_nettype wire

/* File: src/lbs_binning_port.sv */
// limit-test digital output port with binning strobe, AHB-Lite slave
`timescale 1ns/1ps
`default_nettype none
`include "lbs_map.svh"

module lbs_binning_port #(
    parameter int unsigned STROBE_CYC = `LBS_STROBE_CYC
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic nrst_i,
    // ahb-lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // converter, same clock
    input wire logic reading_valid_i,
    input wire logic signed [15:0] reading_i,
    // digital output lines, index 0 is line 1
    output logic [3:0] dout_o
);

    localparam lbs_pkg::lbs_state_t RST = '{
        ctrl: '{pol: `LBS_POL_RESET, lim_en: `LBS_LIMEN_RESET, strobe_en: 1'b0},
        fsm: lbs_pkg::ST_IDLE,
        rdy: 1'b1,
        default: '0
    };
    localparam logic [11:0] PULSE_LAST = 12'(STROBE_CYC - 1);

    lbs_pkg::lbs_state_t st_q;
    lbs_pkg::lbs_state_t st_d;
    logic addr_acc;
    logic cmd_wr;
    logic rp_go;
    logic ev_go;
    logic signed [15:0] ev_rd;
    logic ev_done;
    logic [1:0] ev_fail;
    logic [3:0] new_pat;

    function automatic logic [3:0] drive_lines(input logic [3:0] pat, input logic strb,
                                               input lbs_pkg::lbs_ctrl_t c);
        logic [3:0] v;
        v = pat;
        if (c.strobe_en) begin
            v[3] = strb;
        end
        // active-low lines invert the logical level
        drive_lines = v ^ ~c.pol;
    endfunction

    // hsize is not checked: only whole-word access is supported
    assign addr_acc = hsel_i && htrans_i[1] && hready_i;
    assign cmd_wr = st_q.wr && (st_q.waddr == `LBS_OFF_CMD);
    assign rp_go = cmd_wr && hwdata_i[`LBS_CMD_REPROC_BIT];
    // evaluation only on conversion or reprocess
    assign ev_go = reading_valid_i || rp_go;
    // held reading reused, a fresh one wins
    assign ev_rd = reading_valid_i ? reading_i : st_q.reading;
    assign new_pat = (|ev_fail) ? st_q.fail_pat : st_q.pass_pat;

    lbs_limit_eval u_eval (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .go_i(ev_go),
        .reading_i(ev_rd),
        .lim1_i(st_q.lim1),
        .lim2_i(st_q.lim2),
        .lim_en_i(st_q.ctrl.lim_en),
        .done_o(ev_done),
        .fail_o(ev_fail)
    );

    always_comb begin
        st_d = st_q;
        st_d.rdy = 1'b1;
        // register writes land in the data phase
        st_d.wr = addr_acc && hwrite_i;
        st_d.waddr = haddr_i[7:0];
        if (st_q.wr) begin
            unique case (st_q.waddr)
                `LBS_OFF_CTRL: begin
                    st_d.ctrl.strobe_en = hwdata_i[`LBS_CTRL_STRB_BIT];
                    st_d.ctrl.lim_en = hwdata_i[`LBS_CTRL_LIMEN_LSB +: 2];
                    st_d.ctrl.pol = hwdata_i[`LBS_CTRL_POL_LSB +: 4];
                end
                `LBS_OFF_LIM1: st_d.lim1 = hwdata_i;
                `LBS_OFF_LIM2: st_d.lim2 = hwdata_i;
                `LBS_OFF_PAT: begin
                    st_d.pass_pat = hwdata_i[3:0];
                    st_d.fail_pat = hwdata_i[`LBS_PAT_FAIL_LSB +: 4];
                end
                default: ;
            endcase
        end
        if (cmd_wr && hwdata_i[`LBS_CMD_PRESET_BIT]) begin
            st_d.ctrl.strobe_en = 1'b0;
        end
        if (reading_valid_i) begin
            st_d.reading = reading_i;
        end
        if (ev_done) begin
            st_d.fail = ev_fail;
        end
        // read data is sampled at the address phase
        st_d.hrdata = '0;
        if (addr_acc && !hwrite_i) begin
            unique case (haddr_i[7:0])
                `LBS_OFF_CTRL: st_d.hrdata[6:0] = st_q.ctrl;
                `LBS_OFF_LIM1: st_d.hrdata = st_q.lim1;
                `LBS_OFF_LIM2: st_d.hrdata = st_q.lim2;
                `LBS_OFF_PAT: st_d.hrdata[7:0] = {st_q.fail_pat, st_q.pass_pat};
                `LBS_OFF_STAT: st_d.hrdata = {st_q.reading, 8'h00, st_q.lines,
                                              st_q.strb, |st_q.fail, st_q.fail};
                default: ;
            endcase
        end
        // a result arriving mid-pulse waits so lines stay valid while strobed
        if (ev_done) begin
            st_d.pend = 1'b1;
            st_d.pend_pat = new_pat;
        end
        unique case (st_q.fsm)
            lbs_pkg::ST_IDLE: begin
                if (ev_done || st_q.pend) begin
                    st_d.pend = 1'b0;
                    st_d.pat = ev_done ? new_pat : st_q.pend_pat;
                    if (st_q.ctrl.strobe_en) begin
                        st_d.fsm = lbs_pkg::ST_SETTLE;
                    end
                end
            end
            lbs_pkg::ST_SETTLE: begin
                st_d.fsm = lbs_pkg::ST_PULSE;
                st_d.strb = 1'b1;
                st_d.cnt = '0;
            end
            lbs_pkg::ST_PULSE: begin
                st_d.cnt = st_q.cnt + 12'h001;
                if (st_q.cnt == PULSE_LAST) begin
                    st_d.fsm = lbs_pkg::ST_IDLE;
                    st_d.strb = 1'b0;
                end
            end
        endcase
        if (!st_d.ctrl.strobe_en) begin
            st_d.strb = 1'b0;
            if (st_q.fsm != lbs_pkg::ST_IDLE) begin
                st_d.fsm = lbs_pkg::ST_IDLE;
            end
        end
        st_d.lines = drive_lines(st_q.pat, st_q.strb, st_q.ctrl);
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_q <= RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign hrdata_o = st_q.hrdata;
    assign hreadyout_o = st_q.rdy;
    assign hresp_o = 1'b0;
    assign dout_o = st_q.lines;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);

    logic [11:0] hcnt_q;
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            hcnt_q <= '0;
        end else begin
            hcnt_q <= st_q.strb ? hcnt_q + 12'h001 : 12'h000;
        end
    end

    sequence rp_eval_s;
        rp_go ##1 ev_done;
    endsequence

    enable_query_a: assert property (
        (addr_acc && !hwrite_i && haddr_i[7:0] == `LBS_OFF_CTRL)
        |=> hrdata_o[0] == $past(st_q.ctrl.strobe_en))
        else $error("strobe enable readback wrong");
    preset_clear_a: assert property (
        (cmd_wr && hwdata_i[`LBS_CMD_PRESET_BIT]) |=> !st_q.ctrl.strobe_en)
        else $error("preset left strobe enabled");
    line_four_a: assert property (
        (st_q.ctrl.strobe_en && $stable(st_q.ctrl))
        |=> dout_o[3] == ($past(st_q.strb) ~^ $past(st_q.ctrl.pol[3])))
        else $error("line 4 not driven by strobe");
    pattern_first_a: assert property (
        $rose(st_q.strb) |-> ($stable(st_q.pat) && dout_o[2:0] == (st_q.pat[2:0] ^ ~st_q.ctrl.pol[2:0])))
        else $error("strobe rose before pattern settled");
    pulse_width_a: assert property (
        ($fell(st_q.strb) && st_q.ctrl.strobe_en) |-> hcnt_q == 12'(STROBE_CYC))
        else $error("strobe pulse length wrong");
    strobe_polarity_a: assert property (
        ($rose(st_q.strb) && $stable(st_q.ctrl)) |=> dout_o[3] == st_q.ctrl.pol[3])
        else $error("strobe level ignores polarity");
    reprocess_a: assert property (
        rp_eval_s |=> st_q.fail == $past(ev_fail))
        else $error("reprocess did not update result");
    no_conversion_a: assert property (
        (rp_go && !reading_valid_i) |=> $stable(st_q.reading))
        else $error("reprocess changed held reading");
    line_weights_a: assert property (
        (!st_q.ctrl.strobe_en && $stable(st_q.ctrl))
        |=> dout_o == ($past(st_q.pat) ^ ~$past(st_q.ctrl.pol)))
        else $error("pattern weights mismatch");
    composite_a: assert property (
        (addr_acc && !hwrite_i && haddr_i[7:0] == `LBS_OFF_STAT)
        |=> (hrdata_o[2] == |$past(st_q.fail)) && $stable(st_q.fail) || $past(ev_done))
        else $error("composite fail wrong");

endmodule

`default_nettype wire

/* File: testbench/lbs_binner_model.sv */
// far-side binning circuit model: captures lines 1-3 at each strobe
`timescale 1ns/1ps
`default_nettype none
module lbs_binner_model (
    // clock and reset
    input wire logic mclk_i,
    input wire logic nrst_i,
    // port lines and strobe setup known to the binner
    input wire logic [3:0] dout_i,
    input wire logic strobe_en_i,
    input wire logic pol4_i,
    // captured results
    output logic [2:0] cap_o,
    output logic [7:0] caps_o,
    output logic [15:0] width_o,
    output logic [7:0] early_o
);
    logic act;
    logic act_q;
    logic [2:0] prev_q;
    // strobe is active at the programmed level of line 4
    assign act = strobe_en_i && (dout_i[3] == pol4_i);
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            act_q <= 1'b0;
            prev_q <= 3'h0;
            cap_o <= 3'h0;
            caps_o <= 8'h00;
            width_o <= 16'h0000;
            early_o <= 8'h00;
        end else begin
            act_q <= act;
            prev_q <= dout_i[2:0];
            if (act && !act_q) begin
                cap_o <= dout_i[2:0];
                caps_o <= caps_o + 8'h01;
                width_o <= 16'h0001;
                // lines settled first; a late change would be latched mid-flight
                if (dout_i[2:0] != prev_q) begin
                    early_o <= early_o + 8'h01;
                end
            end else if (act) begin
                width_o <= width_o + 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
// self-checking bench for the binning strobe output port
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // short strobe keeps the run brief
    localparam int unsigned STROBE_CYC = 4;
    logic mclk_i;
    logic nrst_i;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    logic rd_valid;
    logic signed [15:0] reading;
    logic [3:0] dout;
    logic strobe_en;
    logic pol4;
    logic [2:0] cap;
    logic [7:0] caps;
    logic [15:0] width;
    logic [7:0] early;
    logic [31:0] r;
    int bad_count;
    int samples_checked;

    lbs_binning_port #(.STROBE_CYC(STROBE_CYC)) i_lbs_binning_port (
        .mclk_i(mclk_i), .nrst_i(nrst_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
        .hreadyout_o(hready), .hresp_o(hresp), .reading_valid_i(rd_valid), .reading_i(reading),
        .dout_o(dout)
    );
    lbs_binner_model i_lbs_binner_model (
        .mclk_i(mclk_i), .nrst_i(nrst_i), .dout_i(dout), .strobe_en_i(strobe_en), .pol4_i(pol4),
        .cap_o(cap), .caps_o(caps), .width_o(width), .early_o(early)
    );

    initial begin
        mclk_i = 1'b0;
        forever #4 mclk_i = ~mclk_i;
    end

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h000000, a};
        do @(posedge mclk_i); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk_i); while (hready !== 1'b1);
        r = hrdata;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h00000000);
        chk(r, exp);
        chk({31'h00000000, hresp}, 32'h00000000);
    endtask

    task automatic conv(input logic signed [15:0] v, input int n);
        @(posedge mclk_i);
        rd_valid <= 1'b1;
        reading <= v;
        @(posedge mclk_i);
        rd_valid <= 1'b0;
        repeat (n) @(posedge mclk_i);
    endtask

    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // hang guard, well beyond the roughly 150 cycles the tests need
    initial begin
        repeat (3000) @(posedge mclk_i);
        bad_count++;
        tally_and_finish();
    end

    initial begin
        nrst_i = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h00000000;
        rd_valid = 1'b0;
        reading = 16'h0000;
        strobe_en = 1'b0;
        pol4 = 1'b1;
        bad_count = 0;
        samples_checked = 0;
        repeat (20) @(posedge mclk_i);
        nrst_i <= 1'b1;
        rd(8'h00, 32'h00000078);
        rd(8'h20, 32'h00000000);
        rd(8'h14, 32'h00000000);
        bus(1'b1, 8'h08, 32'h0064FF9C);
        bus(1'b1, 8'h10, 32'h0000005B);
        bus(1'b1, 8'h00, 32'h000000F2);
        rd(8'h00, 32'h0000007A);
        chk({28'h0000000, dout}, 32'h00000000);
        conv(16'sd50, 6);
        chk({28'h0000000, dout}, 32'h0000000B);
        rd(8'h14, 32'h003200B0);
        bus(1'b1, 8'h08, 32'h000AFFF6);
        repeat (6) @(posedge mclk_i);
        chk({28'h0000000, dout}, 32'h0000000B);
        rd(8'h14, 32'h003200B0);
        bus(1'b1, 8'h04, 32'h00000001);
        repeat (6) @(posedge mclk_i);
        chk({28'h0000000, dout}, 32'h00000005);
        rd(8'h14, 32'h00320055);
        rd(8'h14, 32'h00320055);
        conv(16'sd20, 6);
        rd(8'h14, 32'h00140055);
        // second window alone fails, composite still set
        bus(1'b1, 8'h0C, 32'h001E0019);
        bus(1'b1, 8'h00, 32'h000000F6);
        rd(8'h0C, 32'h001E0019);
        conv(16'sd5, 6);
        rd(8'h14, 32'h00050056);
        // strobe on, line 4 active low
        bus(1'b1, 8'h00, 32'h00000073);
        rd(8'h00, 32'h0000003B);
        // binner learns the new setup only once line 4 sits at its idle level
        strobe_en <= 1'b1;
        pol4 <= 1'b0;
        chk({28'h0000000, dout}, 32'h0000000D);
        conv(16'sd5, 12);
        chk({29'h00000000, cap}, 32'h00000003);
        chk({16'h0000, width}, STROBE_CYC);
        chk({28'h0000000, dout}, 32'h0000000B);
        conv(16'sd200, 12);
        chk({29'h00000000, cap}, 32'h00000005);
        chk({24'h000000, caps}, 32'h00000002);
        chk({24'h000000, early}, 32'h00000000);
        bus(1'b1, 8'h04, 32'h00000002);
        rd(8'h00, 32'h0000003A);
        tally_and_finish();
    end
endmodule
`default_nettype wire
